// file: hw/cdp_pkg.sv
`default_nettype none
package cdp_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int BYTES      = 8;
    localparam int DATA_W     = 64;
    localparam int CFG_W      = 16;
    localparam int ADDR_W     = 28;
    localparam int BEATS      = 8;

    // ------------------------------------------------------------
    // configuration word fields
    // ------------------------------------------------------------
    localparam int CFG_START  = 0;
    localparam int CFG_WRPAT  = 1;
    localparam int CFG_RANK_L = 2;
    localparam int CFG_BYTE_L = 4;
    localparam int CFG_LOOP_L = 9;
    localparam int LOOP_W     = 7;
    localparam int ST_BUSY    = 0;
    localparam int ST_DONE    = 1;

    // ------------------------------------------------------------
    // register map, byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CONFIG  = 8'h00;
    localparam logic [7:0] OFS_STATUS  = 8'h04;
    localparam logic [7:0] OFS_ERR_LO  = 8'h08;
    localparam logic [7:0] OFS_ERR_HI  = 8'h0c;
    localparam logic [7:0] OFS_IRQ_ST  = 8'h10;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h14;
    localparam logic [7:0] OFS_IRQ_EN  = 8'h18;
    localparam logic [7:0] OFS_READY   = 8'h1c;
    localparam logic [7:0] OFS_IO_ADDR = 8'h20;

    // ------------------------------------------------------------
    // interrupt bits and reset values
    // ------------------------------------------------------------
    localparam int IRQ_W      = 2;
    localparam int IRQ_DONE   = 0;
    localparam int IRQ_MISM   = 1;
    localparam logic [CFG_W-1:0] CFG_RST = 16'h0000;
    localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic [CFG_W-1:0]      cfg;
        logic                  busy;
        logic                  done;
        logic [DATA_W-1:0]     err_log;
        logic [2:0]            beat;
        logic [LOOP_W-1:0]     loop;
        logic [DATA_W-1:0]     rd_data;
        logic [DATA_W-1:0]     cmp;
        logic [DATA_W-1:0]     exp;
        logic [ADDR_W-1:0]     io_addr;
        logic [4*BYTES-1:0]    sync1;
        logic [4*BYTES-1:0]    sync2;
        logic [IRQ_W-1:0]      irq_st;
        logic [IRQ_W-1:0]      irq_en;
        logic                  wr_pend;
        logic [7:0]            wr_addr;
        logic [31:0]           hrdata;
    } cdp_state_t;

endpackage
`default_nettype wire

// file: hw/cdp_probe.sv
// The AHB-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cdp_probe (
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    // ahb-lite slave
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic                           hreadyout,
    output logic                           hresp,
    output logic [31:0]                    hrdata,
    // calibration datapath, same clock
    input  wire logic                      rd_valid_i,
    input  wire logic [63:0]               rd_data_i,
    input  wire logic [63:0]               expected_i,
    input  wire logic                      chk_en_i,
    input  wire logic [27:0]               io_addr_i,
    // phy readiness, foreign domain
    input  wire logic [cdp_pkg::BYTES-1:0] lo_fix_i,
    input  wire logic [cdp_pkg::BYTES-1:0] hi_fix_i,
    input  wire logic [cdp_pkg::BYTES-1:0] lo_phy_i,
    input  wire logic [cdp_pkg::BYTES-1:0] hi_phy_i,
    // debug observation
    output logic [63:0]                    rd_data_o,
    output logic [63:0]                    rd_cmp_o,
    output logic [63:0]                    expected_o,
    output logic [15:0]                    cplx_cfg_o,
    output logic [1:0]                     cplx_status_o,
    output logic [63:0]                    cplx_err_log_o,
    output logic [27:0]                    io_addr_o,
    output logic [cdp_pkg::BYTES-1:0]      lo_nibble_fixed_delay_ok,
    output logic [cdp_pkg::BYTES-1:0]      hi_nibble_fixed_delay_ok,
    output logic [cdp_pkg::BYTES-1:0]      lo_nibble_phys_ok,
    output logic [cdp_pkg::BYTES-1:0]      hi_nibble_phys_ok,
    output logic                           irq
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] byte_of(input logic [63:0] w,
                                           input logic [2:0]  lane);
        byte_of = w[{lane, 3'h0} +: 8];
    endfunction

    // flag for data bit n, beat b lands at 8n+b
    function automatic logic [63:0] log_merge(input logic [63:0] log,
                                              input logic [7:0]  mm,
                                              input logic [2:0]  beat);
        logic [63:0] r;
        r = log;
        for (int n = 0; n < 8; n++) begin
            r[{n[2:0], beat}] = log[{n[2:0], beat}] | mm[n];
        end
        log_merge = r;
    endfunction

    cdp_pkg::cdp_state_t s_r;
    cdp_pkg::cdp_state_t s_nxt;

    logic                           acc_ok;
    logic                           cfg_wr;
    logic                           start_acc;
    logic [2:0]                     lane;
    logic [7:0]                     mism;
    logic [cdp_pkg::LOOP_W-1:0]     loops;
    logic [cdp_pkg::LOOP_W-1:0]     last_loop;
    logic                           run_end;
    logic [cdp_pkg::IRQ_W-1:0]      ev;

    assign acc_ok    = hsel && hready && (htrans == cdp_pkg::HTRANS_NONSEQ);
    assign cfg_wr    = s_r.wr_pend && (s_r.wr_addr == cdp_pkg::OFS_CONFIG);
    assign start_acc = cfg_wr && hwdata[cdp_pkg::CFG_START] && !s_r.busy;
    assign lane      = s_r.cfg[cdp_pkg::CFG_BYTE_L +: 3];
    assign mism      = byte_of(rd_data_i, lane) ^ byte_of(expected_i, lane);
    assign loops     = s_r.cfg[cdp_pkg::CFG_LOOP_L +: cdp_pkg::LOOP_W];
    // a loop count of zero still runs one pass
    assign last_loop = (loops == 7'h00) ? 7'h00 : loops - 7'h01;
    assign run_end   = s_r.busy && rd_valid_i && (s_r.beat == 3'h7)
                       && (s_r.loop == last_loop);
    assign ev[cdp_pkg::IRQ_DONE] = run_end;
    assign ev[cdp_pkg::IRQ_MISM] = s_r.busy && rd_valid_i && (|mism);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        // capture of fifo data and its comparison
        if (rd_valid_i) begin
            s_nxt.rd_data = rd_data_i;
            s_nxt.cmp     = rd_data_i ^ expected_i;
        end
        if (rd_valid_i && chk_en_i) begin
            s_nxt.exp = expected_i;
        end
        s_nxt.io_addr = io_addr_i;
        // readiness bits cross in through two flops
        s_nxt.sync1 = {hi_phy_i, lo_phy_i, hi_fix_i, lo_fix_i};
        s_nxt.sync2 = s_r.sync1;

        // complex pattern run
        if (start_acc) begin
            s_nxt.cfg     = hwdata[15:0];
            s_nxt.busy    = 1'b1;
            s_nxt.done    = 1'b0;
            s_nxt.err_log = 64'h0;
            s_nxt.beat    = 3'h0;
            s_nxt.loop    = 7'h00;
        end else if (cfg_wr && !s_r.busy) begin
            s_nxt.cfg = hwdata[15:0];
        end else if (s_r.busy && rd_valid_i) begin
            s_nxt.err_log = log_merge(s_r.err_log, mism, s_r.beat);
            s_nxt.beat    = s_r.beat + 3'h1;
            if (s_r.beat == 3'h7) begin
                s_nxt.loop = s_r.loop + 7'h01;
            end
            if (run_end) begin
                s_nxt.busy = 1'b0;
                s_nxt.done = 1'b1;
                s_nxt.cfg[cdp_pkg::CFG_START] = 1'b0;
            end
        end

        // interrupt status: hardware set beats software clear
        if (s_r.wr_pend && s_r.wr_addr == cdp_pkg::OFS_IRQ_CLR) begin
            s_nxt.irq_st = s_r.irq_st & ~hwdata[cdp_pkg::IRQ_W-1:0];
        end
        s_nxt.irq_st = s_nxt.irq_st | ev;
        if (s_r.wr_pend && s_r.wr_addr == cdp_pkg::OFS_IRQ_EN) begin
            s_nxt.irq_en = hwdata[cdp_pkg::IRQ_W-1:0];
        end

        // bus: writes land in the data phase, reads are staged
        s_nxt.wr_pend = acc_ok && hwrite;
        s_nxt.wr_addr = haddr[7:0];
        if (acc_ok && !hwrite) begin
            case (haddr[7:0])
                cdp_pkg::OFS_CONFIG:  s_nxt.hrdata = {16'h0000, s_r.cfg};
                cdp_pkg::OFS_STATUS:  s_nxt.hrdata = {30'h0, s_r.done,
                                                      s_r.busy};
                cdp_pkg::OFS_ERR_LO:  s_nxt.hrdata = s_r.err_log[31:0];
                cdp_pkg::OFS_ERR_HI:  s_nxt.hrdata = s_r.err_log[63:32];
                cdp_pkg::OFS_IRQ_ST:  s_nxt.hrdata = {30'h0, s_r.irq_st};
                cdp_pkg::OFS_IRQ_EN:  s_nxt.hrdata = {30'h0, s_r.irq_en};
                cdp_pkg::OFS_READY:   s_nxt.hrdata = s_r.sync2;
                cdp_pkg::OFS_IO_ADDR: s_nxt.hrdata = {4'h0, s_r.io_addr};
                default:              s_nxt.hrdata = 32'h0;
            endcase
        end else begin
            s_nxt.hrdata = 32'h0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // zero wait states keep the probe out of the processor's way
    assign hreadyout      = 1'b1;
    assign hresp          = 1'b0;
    assign hrdata         = s_r.hrdata;
    assign rd_data_o      = s_r.rd_data;
    assign rd_cmp_o       = s_r.cmp;
    assign expected_o     = s_r.exp;
    assign cplx_cfg_o     = s_r.cfg;
    assign cplx_status_o  = {s_r.done, s_r.busy};
    assign cplx_err_log_o = s_r.err_log;
    assign io_addr_o      = s_r.io_addr;
    assign lo_nibble_fixed_delay_ok = s_r.sync2[0 +: cdp_pkg::BYTES];
    assign hi_nibble_fixed_delay_ok = s_r.sync2[cdp_pkg::BYTES +:
                                                cdp_pkg::BYTES];
    assign lo_nibble_phys_ok = s_r.sync2[2*cdp_pkg::BYTES +:
                                         cdp_pkg::BYTES];
    assign hi_nibble_phys_ok = s_r.sync2[3*cdp_pkg::BYTES +:
                                         cdp_pkg::BYTES];
    assign irq = |(s_r.irq_st & s_r.irq_en);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_rd_capture: assert property (
        rd_valid_i |=> rd_data_o == $past(rd_data_i))
        else $error("read data not captured");

    a_cmp_xor: assert property (
        rd_valid_i |=> rd_cmp_o == ($past(rd_data_i) ^ $past(expected_i)))
        else $error("compare word wrong");

    a_exp_hold: assert property (
        !(rd_valid_i && chk_en_i) |=> $stable(expected_o))
        else $error("expected data moved outside check");

    a_start_busy: assert property (
        start_acc |=> cplx_status_o == 2'h1 && cplx_cfg_o[0])
        else $error("start not taken");

    a_busy_done: assert property (
        run_end |=> cplx_status_o == 2'h2 && !cplx_cfg_o[0])
        else $error("run did not finish cleanly");

    a_err_bit0: assert property (
        s_r.busy && rd_valid_i && !start_acc && s_r.beat == 3'h0 && mism[0]
        |=> cplx_err_log_o[0])
        else $error("bit 0 rise0 flag missing");

    a_err_sticky: assert property (
        s_r.busy && !start_acc |=> ($past(cplx_err_log_o) & ~cplx_err_log_o)
                                   == 64'h0)
        else $error("error flag lost");

    a_io_follow: assert property (
        hresetn |=> io_addr_o == $past(io_addr_i))
        else $error("io address not followed");

    a_ready_sync: assert property (
        hresetn && $past(hresetn)
        |=> lo_nibble_phys_ok == $past(lo_phy_i, 2)
            && hi_nibble_fixed_delay_ok == $past(hi_fix_i, 2))
        else $error("ready bits not two flops late");

    a_irq_level: assert property (
        ev[cdp_pkg::IRQ_DONE] && s_r.irq_en[cdp_pkg::IRQ_DONE]
        && !(s_r.wr_pend && s_r.wr_addr == cdp_pkg::OFS_IRQ_EN) |=> irq)
        else $error("done interrupt missing");

    // ------------------------------------------------------------
    // capture path and configuration
    // ------------------------------------------------------------
    a_rd_hold: assert property (
        !rd_valid_i |=> $stable(rd_data_o) && $stable(rd_cmp_o))
        else $error("capture moved without a beat");

    a_exp_take: assert property (
        rd_valid_i && chk_en_i |=> expected_o == $past(expected_i))
        else $error("expected data not taken");

    a_cfg_write: assert property (
        cfg_wr && !s_r.busy
        |=> cplx_cfg_o == $past(hwdata[cdp_pkg::CFG_W-1:0]))
        else $error("config write lost");

    // a write while busy must not retarget a run half way through
    a_cfg_locked: assert property (
        s_r.busy && !run_end |=> $stable(cplx_cfg_o))
        else $error("config moved during run");

    a_loop_step: assert property (
        s_r.busy && rd_valid_i && s_r.beat == 3'h7 && !run_end
        |=> s_r.loop == $past(s_r.loop) + 7'h01)
        else $error("loop count did not advance");

    // ------------------------------------------------------------
    // run status and error log
    // ------------------------------------------------------------
    a_busy_stay: assert property (
        s_r.busy && !run_end |=> cplx_status_o == 2'h1)
        else $error("busy dropped early");

    a_done_hold: assert property (
        s_r.done && !start_acc |=> cplx_status_o == 2'h2)
        else $error("done not held");

    a_status_excl: assert property (
        cplx_status_o != 2'h3)
        else $error("busy and done together");

    a_log_clear: assert property (
        start_acc |=> cplx_err_log_o == 64'h0)
        else $error("log not cleared on start");

    a_log_quiet: assert property (
        !(s_r.busy && rd_valid_i) && !start_acc
        |=> $stable(cplx_err_log_o))
        else $error("log moved without a beat");

    a_err_bit7: assert property (
        s_r.busy && rd_valid_i && mism[7]
        |=> cplx_err_log_o[{3'h7, $past(s_r.beat)}])
        else $error("bit 7 flag missing");

    // ------------------------------------------------------------
    // register bus, interrupt and readiness
    // ------------------------------------------------------------
    a_hrdata_idle: assert property (
        !(acc_ok && !hwrite) |=> hrdata == 32'h0)
        else $error("read data outside data phase");

    a_status_read: assert property (
        acc_ok && !hwrite && haddr[7:0] == cdp_pkg::OFS_STATUS
        |=> hrdata == {30'h0, $past(cplx_status_o)})
        else $error("status read wrong");

    a_errhi_read: assert property (
        acc_ok && !hwrite && haddr[7:0] == cdp_pkg::OFS_ERR_HI
        |=> hrdata == $past(cplx_err_log_o[63:32]))
        else $error("upper log read wrong");

    a_io_read: assert property (
        acc_ok && !hwrite && haddr[7:0] == cdp_pkg::OFS_IO_ADDR
        |=> hrdata == {4'h0, $past(io_addr_o)})
        else $error("io address read wrong");

    // a clear in the same cycle as an event must lose
    a_irq_set_wins: assert property (
        ev != 2'h0 |=> (s_r.irq_st & $past(ev)) == $past(ev))
        else $error("interrupt event lost");

    a_irq_clear: assert property (
        s_r.wr_pend && s_r.wr_addr == cdp_pkg::OFS_IRQ_CLR && ev == 2'h0
        |=> (s_r.irq_st & $past(hwdata[cdp_pkg::IRQ_W-1:0])) == 2'h0)
        else $error("interrupt clear ignored");

    a_ready_fix: assert property (
        hresetn && $past(hresetn)
        |=> lo_nibble_fixed_delay_ok == $past(lo_fix_i, 2)
            && hi_nibble_phys_ok == $past(hi_phy_i, 2))
        else $error("ready bits not two flops late");

    c_run_done: cover property (start_acc ##[1:1000] run_end);
    c_mismatch: cover property (ev[cdp_pkg::IRQ_MISM]);
    c_irq: cover property ($rose(irq));
    c_write_pat: cover property (start_acc && hwdata[1]);
    c_one_pass: cover property (start_acc
        && hwdata[cdp_pkg::CFG_LOOP_L +: cdp_pkg::LOOP_W] == 7'h00);

endmodule
`default_nettype wire

// file: bench/cdp_cal_src.sv
`timescale 1ns/1ps
`default_nettype none
module cdp_cal_src (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        go,
    input  wire logic [7:0]  beats,
    input  wire logic [63:0] base,
    input  wire logic [63:0] flip,
    input  wire logic [2:0]  flip_beat,
    output logic             rd_valid,
    output logic [63:0]      rd_data,
    output logic [63:0]      expected
);
    // ------------------------------------------------------------
    // beat source: word k is base+k, corrupted by flip on every beat whose k[2:0] equals flip_beat
    // ------------------------------------------------------------
    logic [7:0] left;
    logic [7:0] idx;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            left     <= 8'h00;
            idx      <= 8'h00;
            rd_valid <= 1'b0;
            rd_data  <= 64'h0;
            expected <= 64'h0;
        end else if (go) begin
            left     <= beats;
            idx      <= 8'h00;
            rd_valid <= 1'b0;
        end else if (left != 8'h00) begin
            rd_valid <= 1'b1;
            expected <= base + 64'(idx);
            rd_data  <= (base + 64'(idx)) ^
                        ((idx[2:0] == flip_beat) ? flip : 64'h0);
            left     <= left - 8'h01;
            idx      <= idx + 8'h01;
        end else begin
            // idle lines toggle so a stale word can never pass as fresh
            rd_valid <= 1'b0;
            rd_data  <= ~rd_data;
            expected <= ~expected;
        end
    end
endmodule
`default_nettype wire

// file: bench/calibration_debug_probe_tb.sv
`timescale 1ns/1ps
`default_nettype none
module calibration_debug_probe_tb;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0]  htrans = 2'h0, st;
    logic [15:0] cfg;
    logic [63:0] rdo, cmpo, expo, errlog, base = 64'h0, flip = 64'h0;
    logic [27:0] io = 28'h0, ioo;
    logic [7:0]  lf = 8'h0, hf = 8'h0, lp = 8'h0, hp = 8'h0;
    logic [7:0]  lfo, hfo, lpo, hpo, beats = 8'h0;
    logic [2:0]  fb = 3'h0;
    logic        hreadyout, hresp, irq, go = 1'b0, chk_en = 1'b0, rv;
    logic [63:0] rd, ex;
    logic [31:0] r;
    int errors = 0, compares = 0;
    always #5 hclk = ~hclk;
    cdp_cal_src i_src (.hclk(hclk), .hresetn(hresetn), .go(go),
        .beats(beats), .base(base), .flip(flip), .flip_beat(fb),
        .rd_valid(rv), .rd_data(rd), .expected(ex));
    cdp_probe i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .rd_valid_i(rv), .rd_data_i(rd),
        .expected_i(ex), .chk_en_i(chk_en), .io_addr_i(io), .lo_fix_i(lf),
        .hi_fix_i(hf), .lo_phy_i(lp), .hi_phy_i(hp), .rd_data_o(rdo),
        .rd_cmp_o(cmpo), .expected_o(expo), .cplx_cfg_o(cfg),
        .cplx_status_o(st), .cplx_err_log_o(errlog), .io_addr_o(ioo),
        .lo_nibble_fixed_delay_ok(lfo), .hi_nibble_fixed_delay_ok(hfo),
        .lo_nibble_phys_ok(lpo), .hi_nibble_phys_ok(hpo), .irq(irq));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [63:0] s, e);
        compares++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= cdp_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a,
                         input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk(nm, 64'(r), 64'(e));
    endtask
    // beats from the source model; n cycles plus pipeline slack
    task automatic run_beats(input logic [7:0] n, input logic [63:0] s,
                             input logic [63:0] f, input logic [2:0] b);
        @(posedge hclk);
        go    <= 1'b1;
        beats <= n;
        base  <= s;
        flip  <= f;
        fb    <= b;
        @(posedge hclk);
        go <= 1'b0;
        repeat (n + 4) @(posedge hclk);
        #1;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        #1;
        chk("status", 64'(st), 64'h0);
        chk("irq", 64'(irq), 64'h0);
        rdchk("config", cdp_pkg::OFS_CONFIG, 32'h0);
        rdchk("irq_en", cdp_pkg::OFS_IRQ_EN, 32'h0);
        rdchk("unmapped", 8'h40, 32'h0);
    endtask
    task automatic t_datapath;
        chk_en <= 1'b1;
        run_beats(8'd1, 64'h0123_4567_89ab_cdef, 64'hf0, 3'h0);
        chk("rd_data", rdo, 64'h0123_4567_89ab_cd1f);
        chk("rd_cmp", cmpo, 64'hf0);
        chk("expected", expo, 64'h0123_4567_89ab_cdef);
        chk_en <= 1'b0;
        run_beats(8'd1, 64'h55, 64'h3, 3'h0);
        chk("rd_data2", rdo, 64'h56);
        chk("rd_cmp2", cmpo, 64'h3);
        chk("expected_hold", expo, 64'h0123_4567_89ab_cdef);
    endtask
    task automatic t_ready_io;
        @(posedge hclk);
        io <= 28'h9a5_c3e1;
        lf <= 8'h81;
        hf <= 8'h42;
        lp <= 8'h24;
        hp <= 8'h18;
        repeat (3) @(posedge hclk);
        #1;
        chk("io_addr", 64'(ioo), 64'h9a5_c3e1);
        chk("lo_fix", 64'(lfo), 64'h81);
        chk("hi_fix", 64'(hfo), 64'h42);
        chk("lo_phy", 64'(lpo), 64'h24);
        chk("hi_phy", 64'(hpo), 64'h18);
        rdchk("ready", cdp_pkg::OFS_READY, 32'h1824_4281);
        rdchk("io_reg", cdp_pkg::OFS_IO_ADDR, 32'h09a5_c3e1);
    endtask
    // two loops, rank 2, lane 3, write pattern; bit 5 bad on beat 6
    task automatic t_run;
        ahb(1'b1, cdp_pkg::OFS_IRQ_EN, 32'h1);
        ahb(1'b1, cdp_pkg::OFS_CONFIG, 32'h043b);
        @(posedge hclk);
        #1;
        chk("busy", 64'(st), 64'h1);
        chk("cfg", 64'(cfg), 64'h043b);
        ahb(1'b1, cdp_pkg::OFS_CONFIG, 32'h0);
        #1;
        chk("cfg_locked", 64'(cfg), 64'h043b);
        run_beats(8'd16, 64'h7777, 64'h1 << 29, 3'h6);
        chk("done", 64'(st), 64'h2);
        chk("cfg_end", 64'(cfg), 64'h043a);
        chk("err_log", errlog, 64'h1 << (8 * 5 + 6));
        chk("irq_on", 64'(irq), 64'h1);
        rdchk("err_lo", cdp_pkg::OFS_ERR_LO, 32'h0);
        rdchk("err_hi", cdp_pkg::OFS_ERR_HI, 32'h0000_4000);
        rdchk("irq_st", cdp_pkg::OFS_IRQ_ST, 32'h3);
        ahb(1'b1, cdp_pkg::OFS_IRQ_CLR, 32'h1);
        @(posedge hclk);
        #1;
        chk("irq_masked", 64'(irq), 64'h0);
        rdchk("irq_st2", cdp_pkg::OFS_IRQ_ST, 32'h2);
    endtask
    // loops zero runs one pass; lane from low select bits only
    task automatic t_short;
        rdchk("irq_en_rb", cdp_pkg::OFS_IRQ_EN, 32'h1);
        ahb(1'b1, cdp_pkg::OFS_CONFIG, 32'h0091);
        run_beats(8'd7, 64'h0, 64'hff, 3'h3);
        chk("busy7", 64'(st), 64'h1);
        run_beats(8'd1, 64'h0, 64'hff, 3'h0);
        chk("done8", 64'(st), 64'h2);
        chk("cfg_short", 64'(cfg), 64'h0090);
        chk("err_short", errlog, 64'h0);
        rdchk("status_reg", cdp_pkg::OFS_STATUS, 32'h2);
    endtask
    task automatic t_mid_reset;
        ahb(1'b1, cdp_pkg::OFS_CONFIG, 32'h0001);
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        #1;
        chk("status_rst", 64'(st), 64'h0);
        chk("cfg_rst", 64'(cfg), 64'h0);
        chk("irq_rst", 64'(irq), 64'h0);
        rdchk("irq_st_rst", cdp_pkg::OFS_IRQ_ST, 32'h0);
    endtask
    task automatic tally_and_finish;
        if (errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #20000;
        errors++;
        tally_and_finish();
    end
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_datapath();
        t_ready_io();
        t_run();
        t_short();
        t_mid_reset();
        tally_and_finish();
    end
endmodule
`default_nettype wire
